// >>> hdl/dtcd_pkg.sv
// dtcd_pkg: constants and carrier types for the display timing config decoder
// assumes one 100 MHz clock domain and a byte-wide host command stream
package dtcd_pkg;
  localparam logic [7:0] CMD_CLOCK = 8'hD5;
  localparam logic [7:0] CMD_PRECHARGE = 8'hD9;
  localparam logic [7:0] CMD_SEG_CFG = 8'hDA;
  localparam logic [7:0] CMD_VCOM = 8'hDB;
  localparam logic [7:0] CMD_PUMP = 8'h8D;
  localparam logic [7:0] CMD_LOCK = 8'hFD;
  localparam logic [7:0] CMD_NOP = 8'hE3;
  localparam logic [7:0] CMD_DISP_OFF = 8'hAE;
  localparam logic [7:0] CMD_DISP_ON = 8'hAF;
  localparam logic [7:0] CMD_REMAP_OFF = 8'hA0;
  localparam logic [7:0] CMD_REMAP_ON = 8'hA1;
  localparam logic [7:0] PUMP_MODE0 = 8'h12;
  localparam logic [7:0] PUMP_MODE1 = 8'h52;
  localparam logic [7:0] PUMP_MODE2 = 8'h72;
  localparam logic [7:0] PUMP_MODE3 = 8'h92;
  localparam logic [7:0] PUMP_OFF = 8'h10;
  localparam int LOCK_BIT = 2;
  localparam int ORDER_BIT = 4;
  localparam int SWAP_BIT = 5;
  localparam int STATUS_OFF_BIT = 6;
  localparam int STATUS_LOCK_BIT = 5;
  localparam logic [3:0] DIV_RST = 4'h0;
  localparam logic [3:0] OSC_RST = 4'h8;
  localparam logic [7:0] PRECHARGE_RST = 8'h22;
  localparam logic [7:0] VCOM_RST = 8'h20;
  localparam logic [1:0] PUMP_MODE_RST = 2'h0;

  typedef struct packed {
    logic valid;
    logic is_data;
    logic [7:0] value;
  } dtcd_byte_type;

  typedef struct packed {
    logic order_alt;
    logic remap;
    logic swap;
  } dtcd_seg_type;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_PARAM = 1'b1
  } dtcd_state_type;
endpackage

// >>> hdl/dtcd_top.sv
// dtcd_top: command decoder for display clock, precharge, segment, voltage, pump and lock
// assumes host bytes and read requests are synchronous to core_clk_in, one per cycle
//
module dtcd_top
  import dtcd_pkg::*;
#(
  parameter int DIV_W = 4
) (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire dtcd_byte_type host_byte_in,
  input wire logic rd_req_in,
  input wire logic rd_is_data_in,
  input wire logic parallel_mode_in,
  input wire logic clock_source_select_pin_in,
  input wire logic row_start_in,
  output logic [DIV_W-1:0] clk_div_out,
  output logic [3:0] osc_freq_out,
  output logic int_osc_en_out,
  output logic divided_display_clock_tick_out,
  output logic [7:0] precharge_cfg_out,
  output logic precharge_active_out,
  output dtcd_seg_type seg_cfg_out,
  output logic [2:0] seg_case_out,
  output logic [7:0] common_deselect_voltage_out,
  output logic pump_en_out,
  output logic [1:0] pump_mode_out,
  output logic locked_out,
  output logic display_on_out,
  output logic seg_ground_out,
  output logic com_hiz_out,
  output logic display_memory_wr_out,
  output logic [7:0] display_memory_wdata_out,
  output logic display_memory_rd_out,
  output logic status_valid_out,
  output logic [7:0] status_out
);

  dtcd_state_type state_r, state_nxt;
  logic [7:0] pend_cmd_r;
  logic [DIV_W-1:0] div_r;
  logic [3:0] osc_r;
  logic [7:0] pre_r;
  dtcd_seg_type seg_r;
  logic [7:0] vcom_r;
  logic pump_en_r;
  logic [1:0] pump_mode_r;
  logic locked_r;
  logic disp_on_r;
  logic [DIV_W-1:0] div_cnt_r;
  logic tick_r;
  logic [3:0] pc_cnt_r;
  logic mem_wr_r;
  logic [7:0] mem_wdata_r;
  logic mem_rd_r;
  logic stat_vld_r;
  logic [7:0] stat_r;
  logic int_osc_r;
  logic pc_act_r;
  logic seg_gnd_r;
  logic com_hiz_r;

  function automatic logic needs_param(input logic [7:0] c);
    needs_param = (c == CMD_CLOCK) || (c == CMD_PRECHARGE) || (c == CMD_SEG_CFG) ||
                  (c == CMD_VCOM) || (c == CMD_PUMP) || (c == CMD_LOCK);
  endfunction

  // byte classification; while locked only the lock command is taken
  wire logic cmd_byte = host_byte_in.valid && !host_byte_in.is_data;
  wire logic data_byte = host_byte_in.valid && host_byte_in.is_data;
  wire logic cmd_ok = cmd_byte && (!locked_r || host_byte_in.value == CMD_LOCK);
  wire logic first_byte = cmd_ok && (state_r == ST_IDLE);
  wire logic param_byte = cmd_byte && (state_r == ST_PARAM);
  wire logic [7:0] pv = host_byte_in.value;
  wire logic take_clock = param_byte && pend_cmd_r == CMD_CLOCK;
  wire logic take_pre = param_byte && pend_cmd_r == CMD_PRECHARGE;
  wire logic take_seg = param_byte && pend_cmd_r == CMD_SEG_CFG;
  wire logic take_vcom = param_byte && pend_cmd_r == CMD_VCOM;
  wire logic take_pump = param_byte && pend_cmd_r == CMD_PUMP;
  wire logic take_lock = param_byte && pend_cmd_r == CMD_LOCK;
  wire logic pump_on_val = (pv == PUMP_MODE0) || (pv == PUMP_MODE1) ||
                           (pv == PUMP_MODE2) || (pv == PUMP_MODE3);
  wire logic [1:0] pump_mode_val = (pv == PUMP_MODE1) ? 2'h1 :
                                   (pv == PUMP_MODE2) ? 2'h2 :
                                   (pv == PUMP_MODE3) ? 2'h3 : 2'h0;
  wire logic set_remap = first_byte && pv == CMD_REMAP_ON;
  wire logic clr_remap = first_byte && pv == CMD_REMAP_OFF;
  wire logic set_on = first_byte && pv == CMD_DISP_ON;
  wire logic set_off = first_byte && pv == CMD_DISP_OFF;
  wire logic status_req = rd_req_in && !rd_is_data_in && parallel_mode_in;
  wire logic mem_rd_req = rd_req_in && rd_is_data_in && !locked_r;
  // wrap on reaching or passing the limit, so a smaller divider takes effect at once
  wire logic div_wrap = (div_cnt_r >= div_r);
  wire logic [3:0] pc_phase = pre_r[3:0];
  wire logic [3:0] pc_cnt_nxt = row_start_in ? pc_phase :
                                (tick_r && pc_cnt_r != 4'h0) ? pc_cnt_r - 4'h1 : pc_cnt_r;
  wire logic [7:0] stat_val = {1'b0, !disp_on_r, locked_r, 5'h00};

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (first_byte && needs_param(pv)) begin
          state_nxt = ST_PARAM;
        end
      end
      ST_PARAM: begin
        if (param_byte) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      state_r <= ST_IDLE;
      pend_cmd_r <= CMD_NOP;
    end else begin
      state_r <= state_nxt;
      if (first_byte) begin
        pend_cmd_r <= pv;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      div_r <= DIV_W'(DIV_RST);
      osc_r <= OSC_RST;
    end else if (take_clock) begin
      div_r <= pv[DIV_W-1:0];
      osc_r <= pv[7:4];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      pre_r <= PRECHARGE_RST;
      vcom_r <= VCOM_RST;
    end else begin
      if (take_pre) begin
        pre_r <= pv;
      end
      if (take_vcom) begin
        vcom_r <= pv;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      seg_r <= '{order_alt: 1'b1, remap: 1'b0, swap: 1'b0};
    end else begin
      if (take_seg) begin
        seg_r.order_alt <= pv[ORDER_BIT];
        seg_r.swap <= pv[SWAP_BIT];
      end
      if (set_remap) begin
        seg_r.remap <= 1'b1;
      end else if (clr_remap) begin
        seg_r.remap <= 1'b0;
      end
    end
  end

  // unlisted pump values other than the off value are ignored
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      pump_en_r <= 1'b0;
      pump_mode_r <= PUMP_MODE_RST;
    end else if (take_pump && pump_on_val) begin
      pump_en_r <= 1'b1;
      pump_mode_r <= pump_mode_val;
    end else if (take_pump && pv == PUMP_OFF) begin
      pump_en_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      locked_r <= 1'b0;
      disp_on_r <= 1'b0;
      seg_gnd_r <= 1'b1;
      com_hiz_r <= 1'b1;
    end else begin
      if (take_lock) begin
        locked_r <= pv[LOCK_BIT];
      end
      if (set_on) begin
        disp_on_r <= 1'b1;
        seg_gnd_r <= 1'b0;
        com_hiz_r <= 1'b0;
      end else if (set_off) begin
        disp_on_r <= 1'b0;
        seg_gnd_r <= 1'b1;
        com_hiz_r <= 1'b1;
      end
    end
  end

  // divided clock: one tick every div_r+1 source cycles
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      div_cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      div_cnt_r <= div_wrap ? '0 : div_cnt_r + DIV_W'(1);
      tick_r <= div_wrap;
    end
  end

  // precharge lasts pc_phase divided clock ticks after a row start
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      pc_cnt_r <= 4'h0;
      pc_act_r <= 1'b0;
    end else begin
      pc_cnt_r <= pc_cnt_nxt;
      pc_act_r <= (pc_cnt_nxt != 4'h0);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      mem_wr_r <= 1'b0;
      mem_wdata_r <= 8'h00;
      mem_rd_r <= 1'b0;
      stat_vld_r <= 1'b0;
      stat_r <= 8'h00;
      int_osc_r <= 1'b0;
    end else begin
      mem_wr_r <= data_byte && !locked_r;
      if (data_byte) begin
        mem_wdata_r <= pv;
      end
      mem_rd_r <= mem_rd_req;
      stat_vld_r <= status_req;
      stat_r <= status_req ? stat_val : 8'h00;
      int_osc_r <= clock_source_select_pin_in;
    end
  end

  assign clk_div_out = div_r;
  assign osc_freq_out = osc_r;
  assign int_osc_en_out = int_osc_r;
  assign divided_display_clock_tick_out = tick_r;
  assign precharge_cfg_out = pre_r;
  assign precharge_active_out = pc_act_r;
  assign seg_cfg_out = seg_r;
  assign seg_case_out = {seg_r.order_alt, seg_r.remap, seg_r.swap};
  assign common_deselect_voltage_out = vcom_r;
  assign pump_en_out = pump_en_r;
  assign pump_mode_out = pump_mode_r;
  assign locked_out = locked_r;
  assign display_on_out = disp_on_r;
  assign seg_ground_out = seg_gnd_r;
  assign com_hiz_out = com_hiz_r;
  assign display_memory_wr_out = mem_wr_r;
  assign display_memory_wdata_out = mem_wdata_r;
  assign display_memory_rd_out = mem_rd_r;
  assign status_valid_out = stat_vld_r;
  assign status_out = stat_r;

  // checks
  sequence s_clock_param;
    take_clock ##1 1'b1;
  endsequence

  property p_div_update;
    @(posedge core_clk_in) disable iff (srst_in)
      take_clock |=> (div_r == $past(pv[DIV_W-1:0]));
  endproperty
  a_div_update: assert property (p_div_update) else $error("divider not loaded");

  property p_osc_update;
    @(posedge core_clk_in) disable iff (srst_in)
      s_clock_param |-> (osc_r == $past(pv[7:4], 1));
  endproperty
  a_osc_update: assert property (p_osc_update) else $error("oscillator not loaded");

  property p_tick_spacing;
    @(posedge core_clk_in) disable iff (srst_in)
      $rose(tick_r) |-> ##[1:16] tick_r;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("divided tick lost");

  property p_seg_load;
    @(posedge core_clk_in) disable iff (srst_in)
      take_seg |=> seg_r.order_alt == $past(pv[ORDER_BIT]) && seg_r.swap == $past(pv[SWAP_BIT]);
  endproperty
  a_seg_load: assert property (p_seg_load) else $error("segment config wrong");

  property p_vcom_hold;
    @(posedge core_clk_in) disable iff (srst_in)
      (!srst_in && !take_vcom) |=> $stable(vcom_r);
  endproperty
  a_vcom_hold: assert property (p_vcom_hold) else $error("voltage level moved");

  property p_pump;
    @(posedge core_clk_in) disable iff (srst_in)
      (take_pump && pump_on_val) |=> pump_en_r && pump_mode_r == $past(pump_mode_val);
  endproperty
  a_pump: assert property (p_pump) else $error("pump not enabled");

  property p_locked_quiet;
    @(posedge core_clk_in) disable iff (srst_in)
      (!srst_in && locked_r && !take_lock) |=>
        !mem_wr_r && !mem_rd_r && $stable(div_r) && $stable(disp_on_r);
  endproperty
  a_locked_quiet: assert property (p_locked_quiet) else $error("locked device acted");

  property p_unlock;
    @(posedge core_clk_in) disable iff (srst_in)
      (take_lock && !pv[LOCK_BIT]) |=> !locked_r;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock ignored");

  property p_status;
    @(posedge core_clk_in) disable iff (srst_in)
      rd_req_in && !rd_is_data_in |=> status_valid_out == $past(parallel_mode_in);
  endproperty
  a_status: assert property (p_status) else $error("status read wrong");

  property p_off_pins;
    @(posedge core_clk_in) disable iff (srst_in)
      set_off |=> seg_ground_out && com_hiz_out;
  endproperty
  a_off_pins: assert property (p_off_pins) else $error("display off pins wrong");

  property p_nop;
    @(posedge core_clk_in) disable iff (srst_in)
      (first_byte && pv == CMD_NOP) |=> state_r == ST_IDLE && $stable(seg_r) && $stable(locked_r);
  endproperty
  a_nop: assert property (p_nop) else $error("nop changed state");

endmodule // dtcd_top

// >>> verif/dtcd_host_model.sv
// dtcd_host_model: host controller side of the command byte and read port
// assumes callers invoke its tasks right after a rising core clock edge
module dtcd_host_model
  import dtcd_pkg::*;
(
  input wire logic core_clk_in,
  output dtcd_byte_type host_byte_out,
  output logic rd_req_out,
  output logic rd_is_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    host_byte_out = '0;
    rd_req_out = 1'b0;
    rd_is_data_out = 1'b0;
  end
  // byte held until the taking edge; no release so bytes can run back to back
  task automatic put(input logic dc, input logic [7:0] b);
    host_byte_out <= '{1'b1, dc, b};
    @(posedge core_clk_in);
  endtask
  // released byte lane flips so a stale value is never mistaken for data
  task automatic idle();
    host_byte_out <= '{1'b0, 1'b0, ~host_byte_out.value};
  endtask
  task automatic pump_on(input logic [7:0] mode);
    put(1'b0, CMD_PUMP);
    put(1'b0, mode);
    put(1'b0, CMD_DISP_ON);
    idle();
  endtask
  task automatic rd(input logic dc);
    rd_req_out <= 1'b1;
    rd_is_data_out <= dc;
    @(posedge core_clk_in);
    rd_req_out <= 1'b0;
    rd_is_data_out <= ~dc;
  endtask
endmodule // dtcd_host_model

// >>> verif/tb_display_timing_config_decoder.sv
// tb_display_timing_config_decoder: self-checking bench for the decoder top
// assumes the host model drives bytes and reads; the bench drives the other pins
module tb_display_timing_config_decoder
  import dtcd_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic par_mode = 1'b1;
  logic clock_source_select_pin = 1'b1;
  logic row_start = 1'b0;
  dtcd_byte_type hbyte;
  logic rd_req, rd_dc, osc_en, tick, pc_act, pump_en, locked, disp_on, seg_gnd, com_hiz;
  logic mem_wr, mem_rd, st_valid;
  logic [3:0] clk_div, osc;
  logic [7:0] pc_cfg, vcom, wdata, status, p;
  logic [2:0] seg_case;
  logic [1:0] pump_mode;
  dtcd_seg_type seg_cfg;
  logic [7:0] modes [4] = '{PUMP_MODE0, PUMP_MODE1, PUMP_MODE2, PUMP_MODE3};
  logic [31:0] seed = 32'h0000002C;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;

  dtcd_host_model host (.core_clk_in(core_clk_in), .host_byte_out(hbyte),
    .rd_req_out(rd_req), .rd_is_data_out(rd_dc));

  dtcd_top #(.DIV_W(4)) dut (.core_clk_in(core_clk_in), .srst_in(srst_in),
    .host_byte_in(hbyte), .rd_req_in(rd_req), .rd_is_data_in(rd_dc),
    .parallel_mode_in(par_mode), .clock_source_select_pin_in(clock_source_select_pin),
    .row_start_in(row_start), .clk_div_out(clk_div), .osc_freq_out(osc),
    .int_osc_en_out(osc_en), .divided_display_clock_tick_out(tick),
    .precharge_cfg_out(pc_cfg), .precharge_active_out(pc_act), .seg_cfg_out(seg_cfg),
    .seg_case_out(seg_case), .common_deselect_voltage_out(vcom), .pump_en_out(pump_en),
    .pump_mode_out(pump_mode), .locked_out(locked), .display_on_out(disp_on),
    .seg_ground_out(seg_gnd), .com_hiz_out(com_hiz), .display_memory_wr_out(mem_wr),
    .display_memory_wdata_out(wdata), .display_memory_rd_out(mem_rd),
    .status_valid_out(st_valid), .status_out(status));

  initial begin
    forever #5 core_clk_in = ~core_clk_in;
  end

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  function automatic logic [7:0] exp_status(input logic off, input logic lk);
    return {1'b0, off, lk, 5'h00};
  endfunction

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic fin();
    host.idle();
    #1;
  endtask

  task automatic set2(input logic [7:0] c, input logic [7:0] prm);
    host.put(1'b0, c);
    host.put(1'b0, prm);
    fin();
  endtask

  // cycles with precharge active after one row start pulse
  task automatic pc_len(output int len);
    row_start <= 1'b1;
    @(posedge core_clk_in);
    row_start <= 1'b0;
    len = 0;
    repeat (40) begin
      #1;
      if (pc_act === 1'b1) len++;
      @(posedge core_clk_in);
    end
  endtask

  // cycles from one divided clock tick to the next
  task automatic tick_gap(output int gap);
    gap = 0;
    repeat (40) begin
      @(posedge core_clk_in);
      #1;
      if (tick === 1'b1) break;
    end
    repeat (40) begin
      @(posedge core_clk_in);
      #1;
      gap++;
      if (tick === 1'b1) break;
    end
    @(posedge core_clk_in);
  endtask

  initial begin
    repeat (2) @(posedge core_clk_in);
    srst_in <= 1'b0;
    @(posedge core_clk_in);
    #1;
    check({osc, clk_div}, 8'h80);
    check(pc_cfg, PRECHARGE_RST);
    check({5'h00, seg_case}, 8'h04);
    check({5'h00, disp_on, seg_gnd, com_hiz}, 8'h03);
    @(posedge core_clk_in);
    pc_len(n);
    check(8'(n), 8'h02);
    tick_gap(n);
    check(8'(n), 8'h01);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      p = (i == 0) ? 8'h0F : rnd();
      clock_source_select_pin <= p[0];
      set2(CMD_CLOCK, p);
      check({osc, clk_div}, p);
      check({7'h00, osc_en}, {7'h00, p[0]});
      tick_gap(n);
      check(8'(n), {4'h0, p[3:0]} + 8'h01);
      p = rnd();
      set2(CMD_VCOM, p);
      check(vcom, p);
      @(posedge core_clk_in);
      set2(CMD_PRECHARGE, ~p);
      check(pc_cfg, ~p);
      @(posedge core_clk_in);
    end
    $display("test settings done");
    for (int i = 0; i < 8; i++) begin
      host.put(1'b0, i[1] ? CMD_REMAP_ON : CMD_REMAP_OFF);
      set2(CMD_SEG_CFG, {2'h0, i[0], i[2], 4'h2});
      check({5'h00, seg_case}, 8'(i));
      check({5'h00, seg_cfg}, 8'(i));
      @(posedge core_clk_in);
    end
    $display("test segment done");
    for (int i = 0; i < 4; i++) begin
      host.pump_on(modes[i]);
      #1;
      check({5'h00, pump_en, pump_mode}, {5'h00, 1'b1, 2'(i)});
      check({5'h00, disp_on, seg_gnd, com_hiz}, 8'h04);
      @(posedge core_clk_in);
      host.put(1'b0, CMD_DISP_OFF);
      fin();
      check({5'h00, disp_on, seg_gnd, com_hiz}, 8'h03);
      @(posedge core_clk_in);
    end
    set2(CMD_PUMP, PUMP_OFF);
    check({5'h00, pump_en, pump_mode}, 8'h03);
    @(posedge core_clk_in);
    $display("test pump done");
    set2(CMD_CLOCK, 8'h81);
    @(posedge core_clk_in);
    host.put(1'b0, CMD_NOP);
    fin();
    check({osc, clk_div}, 8'h81);
    check({6'h00, mem_wr, locked}, 8'h00);
    @(posedge core_clk_in);
    host.put(1'b0, CMD_CLOCK);
    fin();
    check({osc, clk_div}, 8'h81);
    @(posedge core_clk_in);
    srst_in <= 1'b1;
    @(posedge core_clk_in);
    srst_in <= 1'b0;
    host.put(1'b0, 8'h37);
    fin();
    check({osc, clk_div}, 8'h80);
    $display("test nop and reset done");
    @(posedge core_clk_in);
    set2(CMD_LOCK, 8'h16);
    check({7'h00, locked}, 8'h01);
    @(posedge core_clk_in);
    host.put(1'b0, CMD_CLOCK);
    host.put(1'b0, 8'h3C);
    host.put(1'b1, 8'hA5);
    fin();
    check({osc, clk_div}, 8'h80);
    check({7'h00, mem_wr}, 8'h00);
    @(posedge core_clk_in);
    host.rd(1'b1);
    #1;
    check({7'h00, mem_rd}, 8'h00);
    @(posedge core_clk_in);
    host.rd(1'b0);
    #1;
    check({7'h00, st_valid}, 8'h01);
    check(status, exp_status(1'b1, 1'b1));
    @(posedge core_clk_in);
    par_mode <= 1'b0;
    host.rd(1'b0);
    #1;
    check({7'h00, st_valid}, 8'h00);
    @(posedge core_clk_in);
    par_mode <= 1'b1;
    set2(CMD_LOCK, 8'h12);
    check({7'h00, locked}, 8'h00);
    @(posedge core_clk_in);
    host.put(1'b1, 8'h5A);
    fin();
    check({7'h00, mem_wr}, 8'h01);
    check(wdata, 8'h5A);
    @(posedge core_clk_in);
    host.rd(1'b1);
    #1;
    check({7'h00, mem_rd}, 8'h01);
    $display("test lock done");
    give_verdict();
  end
endmodule // tb_display_timing_config_decoder
